// File: adc_control_registers.sv
// Converter control block: Wishbone registers, acquisition and successive-approximation sequencer.
//
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
module adc_control_registers #(
    parameter int unsigned ADDR_W     = 8,
    parameter int unsigned NUM_INPUTS = 16
) (
    // Clock and reset.
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // Wishbone slave.
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [ADDR_W-1:0]             wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [31:0]                   wb_dat_i,
    output logic      [31:0]                   wb_dat_o,
    output logic                               wb_ack_o,
    // Analog front end.
    input  wire logic                          comparator_i,
    input  wire logic                          rc_osc_i,
    output logic      [3:0]                    channel_sel_o,
    output logic      [1:0]                    reference_sel_o,
    output logic                               sample_o,
    output logic      [adc_ctrl_pkg::RES_W-1:0] dac_code_o,
    output logic      [adc_ctrl_pkg::MAX_INPUTS-1:0] analog_en_o,
    // Interrupt.
    output logic                               irq_o
);
    import adc_ctrl_pkg::*;

    // ************************************************************
    // State.
    // ************************************************************
    logic [7:0]        ctrl0_q, ctrl0_d;
    logic [7:0]        ctrl1_q, ctrl1_d;
    logic [7:0]        ctrl2_q, ctrl2_d;
    logic [7:0]        res_hi_q, res_hi_d;
    logic [7:0]        res_lo_q, res_lo_d;
    logic [7:0]        status_q, status_d;
    logic [7:0]        mask_q, mask_d;
    logic [31:0]       rdat_q, rdat_d;
    logic              ack_q, ack_d;
    conv_state_e       state_q, state_d;
    logic [4:0]        acq_cnt_q, acq_cnt_d;
    logic [3:0]        bit_q, bit_d;
    logic [RES_W-1:0]  dac_q, dac_d;
    logic [2:0]        settle_q, settle_d;
    logic              pend_q, pend_d;
    logic [RES_W-1:0]  final_code;
    logic [4:0]        acq_len;
    logic              bus_wr, bus_rd, abort, done;
    logic              comp_s, rc_s, tad;
    logic [7:0]        pin_sum [MAX_INPUTS];

    // ************************************************************
    // Pin conditioning and conversion clock.
    // ************************************************************
    adc_pin_sync u_comp_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (comparator_i),
        .level_o (comp_s)
    );

    adc_pin_sync u_rc_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .pin_i   (rc_osc_i),
        .level_o (rc_s)
    );

    // The tick source follows the clock field while the sequencer is busy.
    adc_tad_gen u_tad_gen (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .run_i      (state_q != ST_IDLE),
        .clk_sel_i  (ctrl2_q[CLKSEL_LSB +: 3]),
        .rc_level_i (rc_s),
        .tad_o      (tad)
    );

    // ************************************************************
    // Bus decode and sequencer next state.
    // ************************************************************
    // Only byte lane 0 carries the 8-bit registers, so a write needs sel[0].
    assign bus_wr  = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0];
    assign bus_rd  = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;
    assign acq_len = ACQ_TAD_TABLE[ctrl2_q[ACQ_LSB +: 3]];

    always_comb begin
        ctrl0_d    = ctrl0_q;
        ctrl1_d    = ctrl1_q;
        ctrl2_d    = ctrl2_q;
        mask_d     = mask_q;
        status_d   = status_q;
        res_hi_d   = res_hi_q;
        res_lo_d   = res_lo_q;
        rdat_d     = rdat_q;
        ack_d      = wb_cyc_i && wb_stb_i && !ack_q;
        state_d    = state_q;
        acq_cnt_d  = acq_cnt_q;
        bit_d      = bit_q;
        dac_d      = dac_q;
        final_code = dac_q;
        done       = 1'b0;
        pend_d     = 1'b0;
        // Register writes; unimplemented bits are masked away.
        if (bus_wr) begin
            case (wb_adr_i[7:0])
                CHAN_CTRL_OFS: ctrl0_d = wb_dat_i[7:0] & CHAN_CTRL_WMASK;
                REF_PIN_OFS:   ctrl1_d = wb_dat_i[7:0] & REF_PIN_WMASK;
                TIMING_OFS:    ctrl2_d = wb_dat_i[7:0] & TIMING_WMASK;
                IRQ_MASK_OFS:  mask_d  = wb_dat_i[7:0] & IRQ_WMASK;
                default: ;
            endcase
        end
        // Reads; an unmapped address answers zero, and reading status clears it.
        if (bus_rd) begin
            case (wb_adr_i[7:0])
                CHAN_CTRL_OFS:  rdat_d = {24'h000000, ctrl0_q};
                REF_PIN_OFS:    rdat_d = {24'h000000, ctrl1_q};
                TIMING_OFS:     rdat_d = {24'h000000, ctrl2_q};
                RES_HI_OFS:     rdat_d = {24'h000000, res_hi_q};
                RES_LO_OFS:     rdat_d = {24'h000000, res_lo_q};
                IRQ_STATUS_OFS: begin
                    rdat_d   = {24'h000000, status_q};
                    status_d = REG_RST;
                end
                IRQ_MASK_OFS:   rdat_d = {24'h000000, mask_q};
                default:        rdat_d = 32'h00000000;
            endcase
        end
        // Turning the module off or clearing the busy bit aborts with no result.
        abort = (state_q != ST_IDLE) && (!ctrl0_d[ENABLE_BIT] || !ctrl0_d[GO_BIT]);
        if (abort) begin
            state_d          = ST_IDLE;
            ctrl0_d[GO_BIT]  = 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    // A start request only counts while the module is on.
                    if (ctrl0_d[ENABLE_BIT] && ctrl0_d[GO_BIT]) begin
                        if (acq_len == 5'h00) begin
                            state_d = ST_CONV;
                            dac_d   = FIRST_TRIAL;
                            bit_d   = LAST_BIT_IDX;
                        end else begin
                            state_d   = ST_ACQ;
                            acq_cnt_d = acq_len;
                        end
                    end else begin
                        ctrl0_d[GO_BIT] = 1'b0;
                    end
                end
                ST_ACQ: begin
                    if (tad) begin
                        if (acq_cnt_q == 5'h01) begin
                            state_d = ST_CONV;
                            dac_d   = FIRST_TRIAL;
                            bit_d   = LAST_BIT_IDX;
                        end else begin
                            acq_cnt_d = acq_cnt_q - 5'h01;
                        end
                    end
                end
                ST_CONV: begin
                    // One trial bit per period, held back until the comparator has crossed its synchroniser.
                    pend_d = tad || pend_q;
                    if (pend_d && (settle_q == 3'h0)) begin
                        pend_d       = 1'b0;
                        dac_d[bit_q] = comp_s;
                        if (bit_q == 4'h0) begin
                            final_code      = dac_d;
                            done            = 1'b1;
                            state_d         = ST_IDLE;
                            ctrl0_d[GO_BIT] = 1'b0;
                            if (ctrl2_q[JUSTIFY_BIT]) begin
                                res_hi_d = {4'h0, final_code[11:8]};
                                res_lo_d = final_code[7:0];
                            end else begin
                                res_hi_d = final_code[11:4];
                                res_lo_d = {final_code[3:0], 4'h0};
                            end
                        end else begin
                            dac_d[bit_q - 4'h1] = 1'b1;
                            bit_d               = bit_q - 4'h1;
                        end
                    end
                end
                default: state_d = ST_IDLE;
            endcase
        end
        // A new trial code restarts the settling wait; without it the fast dividers would judge stale levels.
        settle_d = (dac_d != dac_q) ? SETTLE_CNT : ((settle_q == 3'h0) ? 3'h0 : settle_q - 3'h1);
        // A completion in the same cycle as a status read is kept.
        if (done) begin
            status_d[DONE_FLAG_BIT] = 1'b1;
        end
    end

    // Register everything; control registers come up zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl0_q   <= REG_RST;
            ctrl1_q   <= REG_RST;
            ctrl2_q   <= REG_RST;
            res_hi_q  <= REG_RST;
            res_lo_q  <= REG_RST;
            status_q  <= REG_RST;
            mask_q    <= REG_RST;
            rdat_q    <= 32'h00000000;
            ack_q     <= 1'b0;
            state_q   <= ST_IDLE;
            acq_cnt_q <= 5'h00;
            bit_q     <= 4'h0;
            dac_q     <= 12'h000;
            settle_q  <= 3'h0;
            pend_q    <= 1'b0;
        end else begin
            ctrl0_q   <= ctrl0_d;
            ctrl1_q   <= ctrl1_d;
            ctrl2_q   <= ctrl2_d;
            res_hi_q  <= res_hi_d;
            res_lo_q  <= res_lo_d;
            status_q  <= status_d;
            mask_q    <= mask_d;
            rdat_q    <= rdat_d;
            ack_q     <= ack_d;
            state_q   <= state_d;
            acq_cnt_q <= acq_cnt_d;
            bit_q     <= bit_d;
            dac_q     <= dac_d;
            settle_q  <= settle_d;
            pend_q    <= pend_d;
        end
    end

    // ************************************************************
    // Outputs.
    // ************************************************************
    // The mux follows the field directly; changing it mid-conversion corrupts the sample.
    assign channel_sel_o   = ctrl0_q[CHAN_LSB +: 4];
    assign reference_sel_o = ctrl1_q[REF_LSB +: 2];
    assign sample_o        = (state_q == ST_ACQ);
    assign dac_code_o      = dac_q;
    assign wb_dat_o        = rdat_q;
    assign wb_ack_o        = ack_q;
    assign irq_o           = |(status_q & mask_q);

    // Pin k is analog while k plus the field stays below fifteen, and every pin is analog when the field is zero; absent pins stay digital.
    genvar k;
    generate
        for (k = 0; k < MAX_INPUTS; k++) begin : g_pin_cfg
            assign pin_sum[k]     = 8'(k) + {4'h0, ctrl1_q[PCFG_LSB +: 4]};
            assign analog_en_o[k] = (k < NUM_INPUTS) &&
                                    ((ctrl1_q[PCFG_LSB +: 4] == 4'h0) || (pin_sum[k] < 8'h0F));
        end
    endgenerate

    // ************************************************************
    // Assertions.
    // ************************************************************
    sequence s_ctrl0_read;
        ack_q && !wb_we_i && (wb_adr_i[7:0] == CHAN_CTRL_OFS);
    endsequence

    sequence s_ctrl1_read;
        ack_q && !wb_we_i && (wb_adr_i[7:0] == REF_PIN_OFS);
    endsequence

    sequence s_start_now;
        (state_q == ST_IDLE) && ctrl0_d[ENABLE_BIT] && ctrl0_d[GO_BIT];
    endsequence

    a_top_bits_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        s_ctrl0_read or s_ctrl1_read |-> wb_dat_o[7:6] == 2'h0)
        else $error("unimplemented control bits read nonzero");

    a_chan_readback: assert property (@(posedge clk_i) disable iff (rst_i)
        s_ctrl0_read |-> wb_dat_o[5:2] == channel_sel_o)
        else $error("channel readback differs from mux select");

    a_ref_readback: assert property (@(posedge clk_i) disable iff (rst_i)
        s_ctrl1_read |-> wb_dat_o[5:4] == reference_sel_o)
        else $error("reference readback differs from output");

    a_busy_reads_one: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q != ST_IDLE) |-> ctrl0_q[GO_BIT] && ctrl0_q[ENABLE_BIT])
        else $error("busy bit low while converting");

    a_off_goes_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !ctrl0_d[ENABLE_BIT] |=> (state_q == ST_IDLE) && !ctrl0_q[GO_BIT])
        else $error("disabled converter left busy");

    a_zero_acq_start: assert property (@(posedge clk_i) disable iff (rst_i)
        s_start_now and (acq_len == 5'h00) |=> (state_q == ST_CONV) && (dac_q == FIRST_TRIAL))
        else $error("zero acquisition did not start conversion at once");

    a_acq_then_conv: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == ST_ACQ) && tad && (acq_cnt_q == 5'h01) && !abort |=> state_q == ST_CONV)
        else $error("acquisition did not hand over to conversion");

    a_done_flags: assert property (@(posedge clk_i) disable iff (rst_i)
        (state_q == ST_CONV) && (tad || pend_q) && (settle_q == 3'h0) && (bit_q == 4'h0) && !abort
        |=> status_q[DONE_FLAG_BIT] && !ctrl0_q[GO_BIT] && (state_q == ST_IDLE))
        else $error("completion did not flag and clear busy");

    a_pins_all_analog: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl1_q[3:0] == 4'h0) |-> analog_en_o[0] && analog_en_o[NUM_INPUTS-1])
        else $error("field zero left a pin digital");

    a_pins_all_digital: assert property (@(posedge clk_i) disable iff (rst_i)
        (ctrl1_q[3:0] == 4'hF) |-> analog_en_o == 16'h0000)
        else $error("field fifteen left a pin analog");

endmodule // adc_control_registers

// File: adc_control_registers_bench.sv
// Self-checking bench of the converter control block.
`timescale 1ns/1ps
module adc_control_registers_bench;
    import adc_ctrl_pkg::*;
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
    // ************************************************************
    // Signals.
    // ************************************************************
    logic        clk_i, rst_i, cyc, stb, we, comparator, rc_osc, wb_ack_o, sample_o, irq_o;
    logic [7:0]  adr, rd;
    logic [31:0] dat, wb_dat_o;
    logic [3:0]  sel, channel_sel_o;
    logic [1:0]  reference_sel_o;
    logic [11:0] dac_code_o, target;
    logic [15:0] analog_en_o;
    int          fail_count, checked, cycles;
    adc_control_registers adc_control_registers_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .comparator_i(comparator), .rc_osc_i(rc_osc), .channel_sel_o(channel_sel_o),
        .reference_sel_o(reference_sel_o), .sample_o(sample_o), .dac_code_o(dac_code_o),
        .analog_en_o(analog_en_o), .irq_o(irq_o));
    adc_front_model adc_front_model_inst (.dac_code_i(dac_code_o), .target_i(target),
        .comparator_o(comparator), .rc_osc_o(rc_osc));
    // ************************************************************
    // Bus tasks.
    // ************************************************************
    // The request stands until ack is seen high at a rising edge; data is taken and the request dropped there.
    task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= {24'h000000, d}; sel <= 4'hF;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && n < 20) begin @(posedge clk_i); n++; end
        if (n == 20) fail_count++;
        rd = wb_dat_o[7:0];
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string nm);
        bus(a, 1'b0, 8'h00);
        `CHK(nm, e, rd)
    endtask
    // Polls the busy bit; status is left alone because reading it clears it.
    task automatic wait_done();
        int n;
        n = 0;
        rd = 8'h02;
        while (rd[1] === 1'b1 && n < 200) begin bus(CHAN_CTRL_OFS, 1'b0, 8'h00); n++; end
        if (n == 200) fail_count++;
    endtask
    // ************************************************************
    // Scenarios.
    // ************************************************************
    task automatic t_reset();
        rdchk(CHAN_CTRL_OFS, 8'h00, "ctrl0 reset");
        rdchk(REF_PIN_OFS, 8'h00, "ctrl1 reset");
        `CHK("analog_en reset", 16'hFFFF, analog_en_o)
        `CHK("irq reset", 1'b0, irq_o)
    endtask
    task automatic t_fields();
        bus(CHAN_CTRL_OFS, 1'b1, 8'hFC);
        rdchk(CHAN_CTRL_OFS, 8'h3C, "ctrl0 top bits");
        `CHK("channel", 4'hF, channel_sel_o)
        bus(CHAN_CTRL_OFS, 1'b1, 8'h02);
        rdchk(CHAN_CTRL_OFS, 8'h00, "go while off");
        bus(REF_PIN_OFS, 1'b1, 8'hDF);
        rdchk(REF_PIN_OFS, 8'h1F, "ctrl1 top bits");
        `CHK("reference 01", 2'h1, reference_sel_o)
        `CHK("all digital", 16'h0000, analog_en_o)
        bus(REF_PIN_OFS, 1'b1, 8'h21);
        `CHK("reference 10", 2'h2, reference_sel_o)
        `CHK("pin code 1", 16'h3FFF, analog_en_o)
        bus(REF_PIN_OFS, 1'b1, 8'h05);
        `CHK("pin code 5", 16'h03FF, analog_en_o)
        rdchk(8'h1C, 8'h00, "unmapped");
    endtask
    // One whole conversion on channel three with the given timing byte and analog level.
    task automatic conv(input logic [7:0] tm, input logic [11:0] t, input logic [7:0] hi, input logic [7:0] lo);
        target <= t;
        bus(TIMING_OFS, 1'b1, tm);
        bus(CHAN_CTRL_OFS, 1'b1, 8'h0F);
        `CHK("sampling", tm[5:3] != 3'h0, sample_o)
        rdchk(CHAN_CTRL_OFS, 8'h0F, "busy");
        wait_done();
        `CHK("ctrl0 done", 8'h0D, rd)
        `CHK("final code", t, dac_code_o)
        rdchk(RES_HI_OFS, hi, "result hi");
        rdchk(RES_LO_OFS, lo, "result lo");
    endtask
    task automatic t_irq();
        bus(IRQ_MASK_OFS, 1'b1, 8'h01);
        conv(8'h8D, 12'hA5C, 8'h0A, 8'h5C);
        `CHK("irq raised", 1'b1, irq_o)
        rdchk(IRQ_STATUS_OFS, 8'h01, "status set");
        rdchk(IRQ_STATUS_OFS, 8'h00, "status cleared");
        `CHK("irq cleared", 1'b0, irq_o)
    endtask
    task automatic t_abort_left();
        bus(IRQ_MASK_OFS, 1'b1, 8'h00);
        bus(CHAN_CTRL_OFS, 1'b1, 8'h0F);
        repeat (20) @(posedge clk_i);
        bus(CHAN_CTRL_OFS, 1'b1, 8'h0D);
        repeat (300) @(posedge clk_i);
        rdchk(IRQ_STATUS_OFS, 8'h00, "abort flag");
        conv(8'h0D, 12'h123, 8'h12, 8'h30);
        `CHK("irq masked", 1'b0, irq_o)
        rdchk(IRQ_STATUS_OFS, 8'h01, "masked status");
    endtask
    // Zero acquisition converts at once; the RC source and the fastest divider pace the trial bits.
    task automatic t_fast();
        conv(8'h03, 12'h7FF, 8'h7F, 8'hF0);
        conv(8'h80, 12'h001, 8'h00, 8'h01);
    endtask
    // ************************************************************
    // Clock, timeout and main sequence.
    // ************************************************************
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    // The ceiling leaves ample margin over four conversions of at most about 240 cycles each.
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin fail_count++; finish_test(); end
    end
    initial begin
        rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; dat = 32'h0; sel = 4'h0;
        target = 12'h000; fail_count = 0; checked = 0; cycles = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_fields();
        t_irq();
        t_abort_left();
        t_fast();
        finish_test();
    end
endmodule // adc_control_registers_bench

// File: adc_ctrl_pkg.sv
// Shared constants, register map and types of the converter control block.
package adc_ctrl_pkg;

    // ************************************************************
    // Converter geometry.
    // ************************************************************
    localparam int unsigned RES_W          = 12;
    localparam int unsigned MAX_INPUTS     = 16;
    localparam logic [3:0]  LAST_BIT_IDX   = 4'hB;
    localparam logic [11:0] FIRST_TRIAL    = 12'h800;
    // Cycles a new trial code needs before the synchronised comparator level reflects it.
    localparam logic [2:0]  SETTLE_CNT     = 3'h4;

    // ************************************************************
    // Register byte offsets on the bus.
    // ************************************************************
    localparam logic [7:0] CHAN_CTRL_OFS   = 8'h00;
    localparam logic [7:0] REF_PIN_OFS     = 8'h04;
    localparam logic [7:0] TIMING_OFS      = 8'h08;
    localparam logic [7:0] RES_HI_OFS      = 8'h0C;
    localparam logic [7:0] RES_LO_OFS      = 8'h10;
    localparam logic [7:0] IRQ_STATUS_OFS  = 8'h14;
    localparam logic [7:0] IRQ_MASK_OFS    = 8'h18;

    // ************************************************************
    // Field positions.
    // ************************************************************
    localparam int unsigned ENABLE_BIT     = 0;
    localparam int unsigned GO_BIT         = 1;
    localparam int unsigned CHAN_LSB       = 2;
    localparam int unsigned REF_LSB        = 4;
    localparam int unsigned PCFG_LSB       = 0;
    localparam int unsigned CLKSEL_LSB     = 0;
    localparam int unsigned ACQ_LSB        = 3;
    localparam int unsigned JUSTIFY_BIT    = 7;
    localparam int unsigned DONE_FLAG_BIT  = 0;

    // ************************************************************
    // Writable masks and values after reset.
    // ************************************************************
    localparam logic [7:0] CHAN_CTRL_WMASK = 8'h3F;
    localparam logic [7:0] REF_PIN_WMASK   = 8'h3F;
    localparam logic [7:0] TIMING_WMASK    = 8'hBF;
    localparam logic [7:0] IRQ_WMASK       = 8'h01;
    localparam logic [7:0] REG_RST         = 8'h00;
    localparam logic [6:0] DIV_CNT_RST     = 7'h00;

    // ************************************************************
    // Timing lookups, indexed by the field code.
    // ************************************************************
    // Divide ratio per clock code; zero marks the internal RC source.
    localparam logic [7:0][6:0] CLK_DIV_TABLE =
        {7'h00, 7'h40, 7'h10, 7'h04, 7'h00, 7'h20, 7'h08, 7'h02};
    // Acquisition length in conversion-clock periods per code.
    localparam logic [7:0][4:0] ACQ_TAD_TABLE =
        {5'h14, 5'h10, 5'h0C, 5'h08, 5'h06, 5'h04, 5'h02, 5'h00};

    // ************************************************************
    // Sequencer states.
    // ************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV} conv_state_e;

endpackage

// File: adc_front_model.sv
// Behavioural model of the analog side: comparator against a target level and a free RC oscillator.
`timescale 1ns/1ps
module adc_front_model (
    // Trial code from the sequencer and the analog level under test.
    input  wire logic [11:0] dac_code_i,
    input  wire logic [11:0] target_i,
    // Comparator and oscillator towards the block.
    output logic             comparator_o,
    output logic             rc_osc_o
);
    // ************************************************************
    // Comparator and oscillator.
    // ************************************************************
    // The comparator answers at once; the block's own synchroniser supplies the delay.
    assign comparator_o = (target_i >= dac_code_i);
    // The oscillator runs free and unrelated to the system clock, as a real RC cell does.
    initial begin
        rc_osc_o = 1'b0;
        forever #37 rc_osc_o = ~rc_osc_o;
    end
endmodule // adc_front_model

// File: adc_pin_sync.sv
// Three-stage synchroniser with agreement filter for one pin input.
`timescale 1ns/1ps
module adc_pin_sync (
    // Clock and reset.
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Pin side and synchronised level.
    input  wire logic pin_i,
    output logic      level_o
);
    import adc_ctrl_pkg::*;

    logic [2:0] stage_q;
    logic [2:0] stage_d;
    logic       level_q;
    logic       level_d;

    // Stage one feeds only stage two; the level moves once stages two and three agree.
    always_comb begin
        stage_d = {stage_q[1:0], pin_i};
        level_d = level_q;
        if (stage_q[1] == stage_q[2]) begin
            level_d = stage_q[2];
        end
    end

    // Register the chain and the filtered level.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage_q <= 3'h0;
            level_q <= 1'b0;
        end else begin
            stage_q <= stage_d;
            level_q <= level_d;
        end
    end

    assign level_o = level_q;

endmodule // adc_pin_sync

// File: adc_tad_gen.sv
// Conversion clock tick generator: system clock divider or internal RC edges.
`timescale 1ns/1ps
module adc_tad_gen (
    // Clock and reset.
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Control.
    input  wire logic       run_i,
    input  wire logic [2:0] clk_sel_i,
    input  wire logic       rc_level_i,
    // One-cycle tick per conversion-clock period.
    output logic            tad_o
);
    import adc_ctrl_pkg::*;

    logic [6:0] div;
    logic [6:0] cnt_q;
    logic [6:0] cnt_d;
    logic       rc_prev_q;
    logic       tad_q;
    logic       tad_d;

    // The counter is held at zero while idle so the first period is a full one.
    always_comb begin
        div   = CLK_DIV_TABLE[clk_sel_i];
        cnt_d = DIV_CNT_RST;
        tad_d = 1'b0;
        if (run_i) begin
            if (div == 7'h00) begin
                tad_d = rc_level_i && !rc_prev_q;
            end else if (cnt_q == div - 7'h01) begin
                tad_d = 1'b1;
            end else begin
                cnt_d = cnt_q + 7'h01;
            end
        end
    end

    // Register counter, RC edge history and tick.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q     <= DIV_CNT_RST;
            rc_prev_q <= 1'b0;
            tad_q     <= 1'b0;
        end else begin
            cnt_q     <= cnt_d;
            rc_prev_q <= rc_level_i;
            tad_q     <= tad_d;
        end
    end

    assign tad_o = tad_q;

endmodule // adc_tad_gen
